//--- mms_master_model.sv
`timescale 1ns/1ps
module mms_master_model
  import mms_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic go_rd,
  input wire logic go_wr,
  input wire logic [MMS_BCNT_W-1:0] go_bcnt,
  input wire logic bus_waitreq,
  output mms_cmd_t bus_cmd,
  output logic busy,
  output logic [7:0] stalls
);
  logic [MMS_BCNT_W-1:0] left_q;
  initial begin
    bus_cmd = '0;
    busy = 1'b0;
    stalls = 8'h00;
    left_q = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // request held until the stall drops; a read is one command beat only
  always @(posedge clk) begin
    if (srst) begin
      bus_cmd <= '0;
      busy <= 1'b0;
      left_q <= '0;
    end else if (go && !busy) begin
      bus_cmd.read <= go_rd;
      bus_cmd.write <= go_wr;
      bus_cmd.burstcount <= go_bcnt;
      bus_cmd.wdata <= 32'h0000a000;
      left_q <= go_rd ? 3'h1 : go_bcnt;
      busy <= 1'b1;
      stalls <= 8'h00;
    end else if (busy) begin
      if (bus_waitreq) begin
        stalls <= stalls + 8'h01;
      end else if (left_q > 3'h1) begin
        left_q <= left_q - 3'h1;
        bus_cmd.wdata <= bus_cmd.wdata + 32'h00000001;
      end else begin
        // strobes drop and wdata flips so stale data never looks valid
        busy <= 1'b0;
        bus_cmd.read <= 1'b0;
        bus_cmd.write <= 1'b0;
        bus_cmd.wdata <= ~bus_cmd.wdata;
      end
    end
  end
endmodule : mms_master_model

//--- mms_pkg.sv
package mms_pkg;

  // bus side widths
  localparam int MMS_ADDR_W = 32;
  localparam int MMS_DATA_W = 32;
  localparam int MMS_BE_W = 4;
  localparam int MMS_BCNT_W = 3;
  localparam int MMS_RESP_W = 8;
  localparam int MMS_ID_W = 8;
  localparam int MMS_IDX_W = 3;
  localparam int MMS_NBEAT = 8;
  localparam int MMS_CNT_W = 16;

  // call/return stream widths
  localparam int MMS_API_W = 64;
  localparam int MMS_CH_W = 8;
  localparam int MMS_ARG_IDX_LSB = 32;

  // function channels on the call stream
  localparam logic [MMS_CH_W-1:0] MMS_FN_WAIT = 8'h00;
  localparam logic [MMS_CH_W-1:0] MMS_FN_MAX_Q = 8'h01;
  localparam logic [MMS_CH_W-1:0] MMS_FN_MIN_Q = 8'h02;
  localparam logic [MMS_CH_W-1:0] MMS_FN_RD_ID = 8'h03;
  localparam logic [MMS_CH_W-1:0] MMS_FN_RD_STATUS = 8'h04;
  localparam logic [MMS_CH_W-1:0] MMS_FN_BURST = 8'h05;
  localparam logic [MMS_CH_W-1:0] MMS_FN_DATA = 8'h06;
  localparam logic [MMS_CH_W-1:0] MMS_FN_LATENCY = 8'h07;
  localparam logic [MMS_CH_W-1:0] MMS_FN_REQ = 8'h08;
  localparam logic [MMS_CH_W-1:0] MMS_FN_TIMEOUT = 8'h09;
  localparam logic [MMS_CH_W-1:0] MMS_FN_WR_ID = 8'h0a;
  localparam logic [MMS_CH_W-1:0] MMS_FN_WR_STATUS = 8'h0b;
  localparam logic [MMS_CH_W-1:0] MMS_FN_MODE = 8'h0c;
  localparam logic [MMS_CH_W-1:0] MMS_FN_MAX_PEND = 8'h0d;
  localparam logic [MMS_CH_W-1:0] MMS_FN_STATUS = 8'h10;
  localparam logic [MMS_CH_W-1:0] MMS_FN_PEND = 8'h11;

  // event channels
  localparam int MMS_EV_FATAL = 0;
  localparam int MMS_EV_EXCESS = 1;
  localparam int MMS_EV_CMD = 2;
  localparam int MMS_EV_RESP = 3;
  localparam int MMS_EV_N = 8;

  // sticky status bit positions
  localparam int MMS_ST_QHIGH = 4;
  localparam int MMS_ST_QLOW = 5;
  localparam int MMS_ST_TMO = 6;

  // request type encoding
  localparam logic MMS_REQ_READ = 1'b0;
  localparam logic MMS_REQ_WRITE = 1'b1;

  // values after reset, then the minimum read latency
  localparam logic [MMS_CNT_W-1:0] MMS_RST_MAX_PEND = 16'h0001;
  localparam logic [MMS_CNT_W-1:0] MMS_RST_TIMEOUT = 16'h0064;
  localparam logic [MMS_CNT_W-1:0] MMS_RST_MAX_Q = 16'hffff;
  localparam logic [MMS_CNT_W-1:0] MMS_RST_MIN_Q = 16'h0000;
  localparam logic [MMS_CNT_W-1:0] MMS_MIN_LAT = 16'h0002;

  typedef struct packed {
    logic read;
    logic write;
    logic [MMS_ADDR_W-1:0] addr;
    logic [MMS_BCNT_W-1:0] burstcount;
    logic [MMS_DATA_W-1:0] wdata;
    logic [MMS_BE_W-1:0] byteen;
  } mms_cmd_t;

  typedef struct packed {
    logic valid;
    logic [MMS_ID_W-1:0] id;
    logic [MMS_RESP_W-1:0] status;
    logic [MMS_DATA_W-1:0] data;
  } mms_rrsp_t;

  typedef struct packed {
    logic valid;
    logic [MMS_ID_W-1:0] id;
    logic [MMS_RESP_W-1:0] status;
  } mms_wrsp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [MMS_CH_W-1:0] chan;
    logic [MMS_API_W-1:0] arg;
  } mms_call_t;

  typedef struct packed {
    logic valid;
    logic [MMS_API_W-1:0] data;
  } mms_ret_t;

endpackage : mms_pkg

//--- mms_slave_responder.sv
`timescale 1ns/1ps
// Behaviour
// - each command beat is stalled by a programmable wait count via waitrequest.
// - write bursts stall each data beat by the wait count at its index.
// - read bursts stall only the command beat, using wait count index zero.
// - read response starts the programmed latency after read accept, clamped to at least two cycles.
// - response request type encodes read as 0 and write as 1.
// - programmed read id appears on the read response id output.
// - programmed write id appears on the write response id output.
// - read response status is programmable per beat index.
// - write response status is programmable per beat index in mode 1; mode 0 always uses index zero.
// - read data words set per index, returned in index order.
// - beats per read response come from programmed burst count.
// - timeout flagged when limit cycles pass without transfer progress.
// - command-received event raised whenever a command is detected.
// - error event when pending reads exceed configured maximum.
// - event when pending responses rise above the maximum threshold.
// - event when pending transactions fall below the minimum threshold.
// - fatal event on an illegal command: both strobes, or a read breaking into a write burst.
// - response-issued event each time a response finishes on the bus.
// - functions and events map to fixed channel numbers, four reserved.
// - calls carry function id on channel, arguments on data; results return.
// - call/return stream shares the single bus clock domain.
// - maximum pending reads defaults to one.
// - mode 0 merges a write burst into one command, mode 1 per beat.
module mms_slave_responder
  import mms_pkg::*;
#(
  parameter int PEND_D = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire mms_cmd_t bus_cmd,
  output logic bus_waitreq,
  output mms_rrsp_t bus_rrsp,
  output mms_wrsp_t bus_wrsp,
  input wire mms_call_t api_call,
  output mms_ret_t api_ret,
  output logic [MMS_EV_N-1:0] evt,
  output logic evt_q_high,
  output logic evt_q_low,
  output logic evt_timeout
);

  localparam int PW = $clog2(PEND_D);
  localparam logic [PW:0] PEND_FULL = (PW+1)'(PEND_D);

  ////////////////////////////////////////////////////////////////////////////
  // programmable settings
  logic [MMS_CNT_W-1:0] wait_q [MMS_NBEAT];
  logic [MMS_RESP_W-1:0] rstat_q [MMS_NBEAT];
  logic [MMS_RESP_W-1:0] wstat_q [MMS_NBEAT];
  logic [MMS_DATA_W-1:0] rdat_q [MMS_NBEAT];
  logic [MMS_CNT_W-1:0] lat_q;
  logic [MMS_CNT_W-1:0] tmo_lim_q;
  logic [MMS_CNT_W-1:0] max_q_q;
  logic [MMS_CNT_W-1:0] min_q_q;
  logic [MMS_CNT_W-1:0] max_pend_q;
  logic [MMS_BCNT_W-1:0] rburst_q;
  logic [MMS_ID_W-1:0] rid_q;
  logic [MMS_ID_W-1:0] wid_q;
  logic req_q;
  logic mode_q;
  logic [7:0] sts_q;
  logic [MMS_IDX_W-1:0] arg_idx;
  logic [MMS_CNT_W-1:0] arg_cnt;

  assign arg_idx = api_call.arg[MMS_ARG_IDX_LSB +: MMS_IDX_W];
  assign arg_cnt = api_call.arg[MMS_CNT_W-1:0];

  // single clock here: one call per cycle, no crossing to keep
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_q <= '0;
      tmo_lim_q <= MMS_RST_TIMEOUT;
      max_q_q <= MMS_RST_MAX_Q;
      min_q_q <= MMS_RST_MIN_Q;
      max_pend_q <= MMS_RST_MAX_PEND;
      rburst_q <= '0;
      rid_q <= '0;
      wid_q <= '0;
      req_q <= MMS_REQ_READ;
      mode_q <= 1'b0;
    end else if (api_call.wr) begin
      case (api_call.chan)
        MMS_FN_MAX_Q: max_q_q <= arg_cnt;
        MMS_FN_MIN_Q: min_q_q <= arg_cnt;
        MMS_FN_RD_ID: rid_q <= api_call.arg[MMS_ID_W-1:0];
        MMS_FN_BURST: rburst_q <= api_call.arg[MMS_BCNT_W-1:0];
        MMS_FN_LATENCY: lat_q <= arg_cnt;
        MMS_FN_REQ: req_q <= api_call.arg[0];
        MMS_FN_TIMEOUT: tmo_lim_q <= arg_cnt;
        MMS_FN_WR_ID: wid_q <= api_call.arg[MMS_ID_W-1:0];
        MMS_FN_MODE: mode_q <= api_call.arg[0];
        MMS_FN_MAX_PEND: max_pend_q <= arg_cnt;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < MMS_NBEAT; i++) begin
        wait_q[i] <= '0;
        rstat_q[i] <= '0;
        wstat_q[i] <= '0;
        rdat_q[i] <= '0;
      end
    end else if (api_call.wr) begin
      if (api_call.chan == MMS_FN_WAIT) begin
        wait_q[arg_idx] <= arg_cnt;
      end
      if (api_call.chan == MMS_FN_RD_STATUS) begin
        rstat_q[arg_idx] <= api_call.arg[MMS_RESP_W-1:0];
      end
      if (api_call.chan == MMS_FN_WR_STATUS) begin
        wstat_q[arg_idx] <= api_call.arg[MMS_RESP_W-1:0];
      end
      if (api_call.chan == MMS_FN_DATA) begin
        rdat_q[arg_idx] <= api_call.arg[MMS_DATA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command plane
  logic cmd_act;
  logic pend_full;
  logic [MMS_CNT_W-1:0] wait_sel;
  logic [MMS_CNT_W-1:0] wcnt_q;
  logic accept;
  logic rd_acc;
  logic wr_acc;
  logic wr_last;
  logic [MMS_IDX_W-1:0] beat_q;
  logic [MMS_BCNT_W-1:0] wlen_q;
  logic [MMS_BCNT_W-1:0] bcnt_in;
  logic [MMS_BCNT_W-1:0] cur_len;
  logic seen_q;
  logic cmd_seen;
  logic fatal;
  logic [PW:0] cnt_q;

  assign cmd_act = bus_cmd.read | bus_cmd.write;
  assign pend_full = (cnt_q == PEND_FULL);
  assign wait_sel = bus_cmd.write ? wait_q[beat_q] : wait_q[0];
  // stall while the count runs; a full queue also back-pressures reads
  assign bus_waitreq = cmd_act & ((wcnt_q < wait_sel) | (bus_cmd.read & pend_full));
  assign accept = cmd_act & ~bus_waitreq;
  assign wr_acc = accept & bus_cmd.write;
  assign rd_acc = accept & bus_cmd.read & ~bus_cmd.write;
  assign bcnt_in = (bus_cmd.burstcount == '0) ? MMS_BCNT_W'(1) : bus_cmd.burstcount;
  assign cur_len = (beat_q == '0) ? bcnt_in : wlen_q;
  assign wr_last = wr_acc & (beat_q == MMS_IDX_W'(cur_len - MMS_BCNT_W'(1)));
  // new command: reads always, writes on first beat or per beat in mode 1
  assign cmd_seen = cmd_act & ~seen_q & (bus_cmd.read | (beat_q == '0) | mode_q);
  // both strobes, or a read breaking into a write burst
  assign fatal = (bus_cmd.read & bus_cmd.write) | (bus_cmd.read & (beat_q != '0));

  always_ff @(posedge clk) begin
    if (srst || accept || !cmd_act) begin
      wcnt_q <= '0;
    end else begin
      wcnt_q <= wcnt_q + MMS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      beat_q <= '0;
      wlen_q <= '0;
    end else if (wr_acc) begin
      beat_q <= wr_last ? '0 : beat_q + MMS_IDX_W'(1);
      if (beat_q == '0) begin
        wlen_q <= bcnt_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || accept || !cmd_act) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  // mode 1 answers every beat, mode 0 once per burst
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_wrsp <= '0;
    end else begin
      bus_wrsp.valid <= mode_q ? wr_acc : wr_last;
      bus_wrsp.id <= wid_q;
      bus_wrsp.status <= wstat_q[mode_q ? beat_q : MMS_IDX_W'(0)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending read queue and response plane
  logic [MMS_CNT_W-1:0] ts_q [PEND_D];
  logic [MMS_CNT_W-1:0] plat_q [PEND_D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_d;
  logic [MMS_CNT_W-1:0] now_q;
  logic [MMS_CNT_W-1:0] age;
  logic [MMS_BCNT_W-1:0] rburst_eff;
  logic [MMS_BCNT_W-1:0] slen_q;
  logic [MMS_IDX_W-1:0] sbeat_q;
  logic strm_q;
  logic due;
  logic last_load;

  assign age = now_q - ts_q[rp_q];
  assign rburst_eff = (rburst_q == '0) ? MMS_BCNT_W'(1) : rburst_q;
  // load one cycle early so the registered beat lands on the latency
  assign due = (cnt_q != '0) & ~strm_q & ((age + MMS_CNT_W'(1)) >= plat_q[rp_q]);
  assign last_load = (due & (rburst_eff == MMS_BCNT_W'(1)))
                   | (strm_q & (sbeat_q == MMS_IDX_W'(slen_q - MMS_BCNT_W'(1))));
  assign cnt_d = cnt_q + (PW+1)'(rd_acc) - (PW+1)'(last_load);

  always_ff @(posedge clk) begin
    if (srst) begin
      now_q <= '0;
    end else begin
      now_q <= now_q + MMS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (rd_acc) begin
        wp_q <= (wp_q == PW'(PEND_D - 1)) ? '0 : wp_q + PW'(1);
      end
      if (last_load) begin
        rp_q <= (rp_q == PW'(PEND_D - 1)) ? '0 : rp_q + PW'(1);
      end
    end
  end

  // latency is captured at accept, so later changes hit only new reads
  always_ff @(posedge clk) begin
    if (rd_acc) begin
      ts_q[wp_q] <= now_q;
      plat_q[wp_q] <= (lat_q < MMS_MIN_LAT) ? MMS_MIN_LAT : lat_q;
    end
  end

  // beat count from programmed burst size
  always_ff @(posedge clk) begin
    if (srst) begin
      strm_q <= 1'b0;
      sbeat_q <= '0;
      slen_q <= '0;
      bus_rrsp <= '0;
    end else if (due) begin
      bus_rrsp.valid <= 1'b1;
      bus_rrsp.id <= rid_q;
      bus_rrsp.data <= rdat_q[0];
      bus_rrsp.status <= rstat_q[0];
      slen_q <= rburst_eff;
      sbeat_q <= MMS_IDX_W'(1);
      strm_q <= (rburst_eff != MMS_BCNT_W'(1));
    end else if (strm_q) begin
      bus_rrsp.valid <= 1'b1;
      bus_rrsp.id <= rid_q;
      bus_rrsp.data <= rdat_q[sbeat_q];
      bus_rrsp.status <= rstat_q[sbeat_q];
      sbeat_q <= sbeat_q + MMS_IDX_W'(1);
      if (last_load) begin
        strm_q <= 1'b0;
      end
    end else begin
      bus_rrsp.valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout
  logic [MMS_CNT_W-1:0] tmo_q;
  logic busy;
  logic progress;
  logic tmo_hit;

  assign busy = (cnt_q != '0) | (beat_q != '0) | bus_waitreq;
  assign progress = accept | due | strm_q;
  // limit reached without progress; zero limit disables it
  assign tmo_hit = busy & ~progress & (tmo_lim_q != '0)
                 & ((tmo_q + MMS_CNT_W'(1)) == tmo_lim_q);

  always_ff @(posedge clk) begin
    if (srst || !busy || progress) begin
      tmo_q <= '0;
    end else begin
      tmo_q <= tmo_q + MMS_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and status
  logic excess;
  logic q_high;
  logic q_low;
  logic [7:0] sts_set;
  logic [7:0] sts_clr;

  assign excess = rd_acc & (MMS_CNT_W'(cnt_d) > max_pend_q);
  assign q_high = (MMS_CNT_W'(cnt_d) > max_q_q) & (MMS_CNT_W'(cnt_q) <= max_q_q);
  assign q_low = (MMS_CNT_W'(cnt_d) < min_q_q) & (MMS_CNT_W'(cnt_q) >= min_q_q);
  assign sts_set = {1'b0, tmo_hit, q_low, q_high, last_load | bus_wrsp.valid,
                    cmd_seen, excess, fatal};
  assign sts_clr = (api_call.wr && api_call.chan == MMS_FN_STATUS) ? api_call.arg[7:0] : '0;

  // fixed channels, upper four reserved and quiet
  // response done: last read beat or write answer
  always_ff @(posedge clk) begin
    if (srst) begin
      evt <= '0;
      evt_q_high <= 1'b0;
      evt_q_low <= 1'b0;
      evt_timeout <= 1'b0;
    end else begin
      evt <= '0;
      evt[MMS_EV_FATAL] <= fatal;
      evt[MMS_EV_EXCESS] <= excess;
      evt[MMS_EV_CMD] <= cmd_seen;
      evt[MMS_EV_RESP] <= last_load | bus_wrsp.valid;
      evt_q_high <= q_high;
      evt_q_low <= q_low;
      evt_timeout <= tmo_hit;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      sts_q <= '0;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
    end
  end

  // results on the return stream, one cycle after the call
  always_ff @(posedge clk) begin
    if (srst || !api_call.rd) begin
      api_ret <= '0;
    end else begin
      api_ret.valid <= 1'b1;
      case (api_call.chan)
        MMS_FN_WAIT: api_ret.data <= MMS_API_W'(wait_q[arg_idx]);
        MMS_FN_MAX_Q: api_ret.data <= MMS_API_W'(max_q_q);
        MMS_FN_MIN_Q: api_ret.data <= MMS_API_W'(min_q_q);
        MMS_FN_RD_ID: api_ret.data <= MMS_API_W'(rid_q);
        MMS_FN_BURST: api_ret.data <= MMS_API_W'(rburst_q);
        MMS_FN_LATENCY: api_ret.data <= MMS_API_W'(lat_q);
        MMS_FN_REQ: api_ret.data <= MMS_API_W'(req_q);
        MMS_FN_TIMEOUT: api_ret.data <= MMS_API_W'(tmo_lim_q);
        MMS_FN_WR_ID: api_ret.data <= MMS_API_W'(wid_q);
        MMS_FN_MODE: api_ret.data <= MMS_API_W'(mode_q);
        MMS_FN_MAX_PEND: api_ret.data <= MMS_API_W'(max_pend_q);
        MMS_FN_STATUS: api_ret.data <= MMS_API_W'(sts_q);
        MMS_FN_PEND: api_ret.data <= MMS_API_W'(cnt_q);
        default: api_ret.data <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_WAIT_READ: assert property (@(posedge clk) disable iff (srst)
    (bus_cmd.read && !bus_cmd.write && !$past(cmd_act) && wait_q[0] == 16'h0001 && !pend_full)
      ##1 bus_cmd.read |-> $past(bus_waitreq) && !bus_waitreq)
    else $error("read wait count not honoured");

  AST_WR_BEAT: assert property (@(posedge clk) disable iff (srst)
    wr_acc |-> wcnt_q >= wait_q[beat_q] && $past(bus_waitreq) == (wcnt_q != '0))
    else $error("write beat accepted before its wait");

  AST_RD_IDX0: assert property (@(posedge clk) disable iff (srst)
    rd_acc |-> wcnt_q >= wait_q[0] && (wcnt_q == wait_q[0] || $past(pend_full)))
    else $error("read accepted before index zero wait");

  AST_RD_LAT: assert property (@(posedge clk) disable iff (srst)
    (rd_acc && cnt_q == '0 && !strm_q && lat_q == 16'h0003)
      |-> ##1 !bus_rrsp.valid [*2] ##1 bus_rrsp.valid)
    else $error("read latency wrong");

  AST_RD_ID: assert property (@(posedge clk) disable iff (srst)
    (due && !api_call.wr) |=> bus_rrsp.valid && bus_rrsp.id == $past(rid_q))
    else $error("read id wrong");

  AST_WR_ID: assert property (@(posedge clk) disable iff (srst)
    (wr_last && !mode_q) |=> bus_wrsp.valid && bus_wrsp.id == $past(wid_q))
    else $error("write id or response missing");

  AST_BEATS: assert property (@(posedge clk) disable iff (srst)
    (due && rburst_eff == 3'h2) |=> bus_rrsp.valid [*2] ##0 evt[MMS_EV_RESP])
    else $error("burst beat count wrong");

  AST_EXCESS: assert property (@(posedge clk) disable iff (srst)
    (rd_acc && !last_load && MMS_CNT_W'(cnt_q) >= max_pend_q) |=> evt[MMS_EV_EXCESS])
    else $error("excess pending reads not flagged");

  AST_CMD_SEEN: assert property (@(posedge clk) disable iff (srst)
    (bus_cmd.read && !$past(cmd_act)) |=> evt[MMS_EV_CMD])
    else $error("command not reported");

  AST_RESET: assert property (@(posedge clk)
    $past(srst) |-> !bus_waitreq && cnt_q == '0 && lat_q == '0)
    else $error("reset state wrong");

  COV_RD_BURST: cover property (@(posedge clk) disable iff (srst)
    due && rburst_eff == 3'h2);
  COV_WR_SPLIT: cover property (@(posedge clk) disable iff (srst)
    wr_acc && mode_q && beat_q == 3'h1);
  COV_TIMEOUT: cover property (@(posedge clk) disable iff (srst) tmo_hit);

endmodule : mms_slave_responder

//--- tb_mms_slave_responder.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_mms_slave_responder
  import mms_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic go_rd = 1'b0;
  logic go_wr = 1'b0;
  logic [MMS_BCNT_W-1:0] go_bcnt = '0;
  logic busy;
  logic [7:0] stalls;
  mms_cmd_t bus_cmd;
  logic bus_waitreq;
  mms_rrsp_t bus_rrsp;
  mms_wrsp_t bus_wrsp;
  mms_call_t api_call = '0;
  mms_ret_t api_ret;
  logic [MMS_EV_N-1:0] evt;
  logic evt_q_high, evt_q_low, evt_timeout;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int acc_cyc = 0;
  int rsp_cyc = 0;
  int n_wr = 0;
  logic [7:0] ev_seen = 8'h00;
  logic [7:0] ev_all = 8'h00;
  logic qh = 1'b0, ql = 1'b0, tm = 1'b0;
  logic clr_req = 1'b0;
  logic [31:0] rdat[$];
  logic [7:0] rst_q[$];
  logic [7:0] rid_q[$];
  mms_wrsp_t last_w;

  always #2 clk = ~clk;

  mms_slave_responder #(.PEND_D(4)) i_dut (.clk(clk), .srst(srst), .bus_cmd(bus_cmd),
    .bus_waitreq(bus_waitreq), .bus_rrsp(bus_rrsp), .bus_wrsp(bus_wrsp), .api_call(api_call),
    .api_ret(api_ret), .evt(evt), .evt_q_high(evt_q_high), .evt_q_low(evt_q_low),
    .evt_timeout(evt_timeout));
  mms_master_model i_mst (.clk(clk), .srst(srst), .go(go), .go_rd(go_rd), .go_wr(go_wr),
    .go_bcnt(go_bcnt), .bus_waitreq(bus_waitreq), .bus_cmd(bus_cmd), .busy(busy),
    .stalls(stalls));
  ////////////////////////////////////////////////////////////////////////////////
  // bus watcher; pulses are folded into sticky copies
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!srst) begin
      ev_all <= ev_all | evt;
    end
    // sticky copies are cleared here only, so one process owns them
    if (clr_req) begin
      rdat.delete();
      rst_q.delete();
      rid_q.delete();
      ev_seen <= 8'h00;
      qh <= 1'b0;
      ql <= 1'b0;
      tm <= 1'b0;
      n_wr <= 0;
    end else if (!srst) begin
      ev_seen <= ev_seen | evt;
      qh <= qh | evt_q_high;
      ql <= ql | evt_q_low;
      tm <= tm | evt_timeout;
      if (bus_cmd.read && !bus_waitreq) acc_cyc <= cyc;
      if (bus_rrsp.valid) begin
        if (rdat.size() == 0) rsp_cyc <= cyc;
        rdat.push_back(bus_rrsp.data);
        rst_q.push_back(bus_rrsp.status);
        rid_q.push_back(bus_rrsp.id);
      end
      if (bus_wrsp.valid) begin
        n_wr <= n_wr + 1;
        last_w <= bus_wrsp;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic call(input logic wr, input logic [7:0] ch, input logic [2:0] idx,
                      input logic [31:0] v);
    @(posedge clk);
    api_call <= '{wr: wr, rd: !wr, chan: ch, arg: {29'h0, idx, v}};
    @(posedge clk);
    api_call <= '0;
    #1;
  endtask : call

  task automatic rd_chk(input logic [7:0] ch, input logic [2:0] idx, input logic [63:0] e);
    call(1'b0, ch, idx, 32'h0);
    `CHK(api_ret.valid, 1'b1)
    `CHK(api_ret.data, e)
  endtask : rd_chk

  task automatic run(input logic rd, input logic wr, input logic [2:0] bc);
    @(posedge clk);
    go <= 1'b1;
    go_rd <= rd;
    go_wr <= wr;
    go_bcnt <= bc;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 100 && busy; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : run

  task automatic clr();
    @(posedge clk);
    clr_req <= 1'b1;
    @(posedge clk);
    clr_req <= 1'b0;
  endtask : clr

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // ceiling well above the few hundred cycles the tests need
    fork
      begin
        wait (cyc >= 3000);
        n_fail++;
        report_and_stop();
      end
    join_none
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd_chk(MMS_FN_MAX_PEND, 3'h0, 64'h1);
    rd_chk(MMS_FN_LATENCY, 3'h0, 64'h0);
    rd_chk(MMS_FN_WAIT, 3'h0, 64'h0);
    rd_chk(MMS_FN_MODE, 3'h0, 64'h0);
    rd_chk(MMS_FN_TIMEOUT, 3'h0, {48'h0, MMS_RST_TIMEOUT});
    rd_chk(8'h0f, 3'h0, 64'h0);
    call(1'b1, MMS_FN_REQ, 3'h0, {31'h0, MMS_REQ_WRITE});
    rd_chk(MMS_FN_REQ, 3'h0, 64'h1);
    tend("defaults");
    // read: one wait, latency 3, two beats, thresholds straddling one pending
    call(1'b1, MMS_FN_WAIT, 3'h0, 32'h1);
    call(1'b1, MMS_FN_LATENCY, 3'h0, 32'h3);
    call(1'b1, MMS_FN_BURST, 3'h0, 32'h2);
    call(1'b1, MMS_FN_DATA, 3'h0, 32'h11110000);
    call(1'b1, MMS_FN_DATA, 3'h1, 32'h22220000);
    call(1'b1, MMS_FN_RD_STATUS, 3'h0, 32'h1);
    call(1'b1, MMS_FN_RD_STATUS, 3'h1, 32'h2);
    call(1'b1, MMS_FN_RD_ID, 3'h0, 32'h5a);
    call(1'b1, MMS_FN_MAX_Q, 3'h0, 32'h0);
    call(1'b1, MMS_FN_MIN_Q, 3'h0, 32'h1);
    clr();
    run(1'b1, 1'b0, 3'h1);
    repeat (10) @(posedge clk);
    #1;
    `CHK(stalls, 8'h01)
    `CHK(rsp_cyc - acc_cyc, 3)
    `CHK(rdat.size(), 2)
    `CHK(rdat[0], 32'h11110000)
    `CHK(rdat[1], 32'h22220000)
    `CHK(rst_q[0], 8'h01)
    `CHK(rst_q[1], 8'h02)
    `CHK(rid_q[0], 8'h5a)
    `CHK(ev_seen[MMS_EV_CMD], 1'b1)
    `CHK(ev_seen[MMS_EV_RESP], 1'b1)
    `CHK(qh, 1'b1)
    `CHK(ql, 1'b1)
    tend("read");
    // write burst of two, second beat stalled twice
    call(1'b1, MMS_FN_WAIT, 3'h0, 32'h0);
    call(1'b1, MMS_FN_WAIT, 3'h1, 32'h2);
    call(1'b1, MMS_FN_WR_ID, 3'h0, 32'h3c);
    call(1'b1, MMS_FN_WR_STATUS, 3'h0, 32'h2);
    clr();
    run(1'b0, 1'b1, 3'h2);
    repeat (4) @(posedge clk);
    #1;
    `CHK(stalls, 8'h02)
    `CHK(n_wr, 1)
    `CHK(last_w.id, 8'h3c)
    `CHK(last_w.status, 8'h02)
    call(1'b1, MMS_FN_MODE, 3'h0, 32'h1);
    clr();
    run(1'b0, 1'b1, 3'h2);
    repeat (4) @(posedge clk);
    #1;
    `CHK(n_wr, 2)
    tend("write");
    clr();
    run(1'b1, 1'b1, 3'h1);
    repeat (12) @(posedge clk);
    `CHK(ev_seen[MMS_EV_FATAL], 1'b1)
    tend("fatal");
    // second read queued while the first waits out a long latency
    call(1'b1, MMS_FN_LATENCY, 3'h0, 32'h14);
    clr();
    run(1'b1, 1'b0, 3'h1);
    run(1'b1, 1'b0, 3'h1);
    repeat (40) @(posedge clk);
    `CHK(ev_seen[MMS_EV_EXCESS], 1'b1)
    tend("excess");
    call(1'b1, MMS_FN_TIMEOUT, 3'h0, 32'h5);
    call(1'b1, MMS_FN_WAIT, 3'h0, 32'h14);
    clr();
    run(1'b1, 1'b0, 3'h1);
    `CHK(stalls, 8'h14)
    repeat (30) @(posedge clk);
    `CHK(tm, 1'b1)
    `CHK(ev_all[7:4], 4'h0)
    tend("timeout");
    report_and_stop();
  end
endmodule : tb_mms_slave_responder
